// [hw/timer_ctl.v]
/*
 * Control part of a four-channel 16-bit capture/compare timer with an
 * APB register slave. Channels are numbered 4..7 (port bits 0..3).
 * Assumes edge detection, output action codes, prescaler select and the
 * pulse accumulator live outside and reach this block as plain inputs.
 */
`timescale 1ns/1ps
`include "timer_ctl_consts.vh"

// What this block does
// [R01] Direction bit 0 makes a channel capture, 1 makes it compare.
// [R02] The force register always reads back as zero.
// [R03] Writing a force bit does the compare action now, without a flag.
// [R04] Force and real match together: forced action wins, flag stays clear.
// [R05] Channel 7 compare beats channels 6..4 on every pin it masks.
// [R06] Mask bit plus compare direction turns channel 4..7 pin into output.
// [R07] On channel 7 compare, masked pins take the override data bits.
// [R08] Main counter is 16 bits, counting up once per prescaled tick.
// [R09] A word access reads or loads the whole counter in one cycle.
// [R10] Counter writes are ignored unless test mode is 1.
// [R11] First interval after a counter write may be short or long.
// [R12] Enable bit 7 clear halts the timer, counter included; force writes still act.
// [R13] When the timer is inactive the divide-by-64 tick stops.
// [R14] Stop-in-wait bit 6 halts timer and accumulator tick in wait mode.
// [R15] Stop-in-freeze bit 5 halts only the counter in freeze mode.
// [R16] Fast clear: capture read or compare write clears channel flag.
// [R17] Fast clear: any counter byte access clears the overflow flag.
// [R18] Fast clear: accumulator count access clears both its flags.
// [R19] Fast clear off: accesses leave the flags alone.
// [R20] Normal clearing: writing 1 to a flag bit clears it.
module timer_ctl #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire test_mode,
  input wire wait_mode,
  input wire freeze_mode,
  input wire [2:0] prescale_sel,
  input wire [7:0] output_action,
  input wire [3:0] capture_event,
  input wire acc_overflow_event,
  input wire acc_input_event,
  input wire [15:0] accumulator_count,
  output reg [3:0] timer_pin_out,
  output wire [3:0] timer_pin_oe,
  output reg [3:0] channel_flag,
  output reg counter_overflow_flag,
  output reg accumulator_overflow_flag,
  output reg accumulator_input_flag,
  output wire div64_tick,
  output wire timer_wake_enable
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [1:0] act_code;
    input [7:0] codes;
    input [1:0] ch;
    begin
      act_code = codes[ch*2 +: 2];
    end
  endfunction

  function apply_act;
    input pin;
    input [1:0] code;
    begin
      case (code)
        `ACT_TOGGLE: apply_act = ~pin;
        `ACT_CLEAR: apply_act = 1'b0;
        `ACT_SET: apply_act = 1'b1;
        default: apply_act = pin;
      endcase
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] dir_q;
  reg [7:0] ovr_mask_q;
  reg [7:0] ovr_data_q;
  reg [3:0] sysctl_q;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [6:0] pre_q;
  reg [15:0] tc_q [0:3];
  reg [3:0] pin_d;
  reg [3:0] chf_d;
  reg tof_d;
  reg accumulator_overflow_flag_d;
  reg accumulator_input_flag_d;
  reg [31:0] rd_d;
  integer i;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire [5:0] idx = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire is_tc = (idx >= `IDX_TC_FIRST) && (idx <= `IDX_TC_LAST);
  wire [1:0] tc_ch = idx[2:1];
  wire mapped = aligned && (idx <= `IDX_SYSCTL || idx == `IDX_CH_FLAG ||
    idx == `IDX_OVF_FLAG || is_tc || idx == `IDX_ACC_FLAG ||
    idx == `IDX_ACC_HI || idx == `IDX_ACC_LO || idx == `IDX_CNT_WORD);
  wire access = psel && penable && mapped;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire cnt_acc = access && (idx == `IDX_CNT_HI || idx == `IDX_CNT_LO ||
    idx == `IDX_CNT_WORD);
  wire acc_acc = access && (idx == `IDX_ACC_HI || idx == `IDX_ACC_LO);
  wire ffca = sysctl_q[`SC_FFCA];

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ****************************************************************
  // Activity and prescaler
  // ****************************************************************
  wire active = sysctl_q[`SC_TEN] &&
    !(sysctl_q[`SC_SWAI] && wait_mode); // [R12] [R14]
  wire cnt_run = active && !(sysctl_q[`SC_SFRZ] && freeze_mode); // [R15]
  wire [6:0] pre_mask = `PRE_MAX >> (3'h7 - prescale_sel);
  wire tick = cnt_run && ((pre_q & pre_mask) == pre_mask); // [R08]
  assign div64_tick = active && (pre_q[5:0] == `DIV64_MASK); // [R13]
  assign timer_wake_enable = !(sysctl_q[`SC_SWAI] && wait_mode); // [R14]

  // ****************************************************************
  // Compare and force events
  // ****************************************************************
  wire [15:0] cnt_inc = cnt_q + 16'h0001;
  wire [3:0] force_w = (wr && idx == `IDX_FORCE) ? pwdata[7:4] : 4'h0;
  reg [3:0] match;
  reg [3:0] fire;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      match[i] = dir_q[4+i] && tick && (cnt_inc == tc_q[i]);
      fire[i] = dir_q[4+i] && (match[i] || force_w[i]); // [R03]
    end
  end

  // Pin drive: compare direction with a mask bit or a nonzero action code
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : oe_gen
      assign timer_pin_oe[g] = dir_q[4+g] && (ovr_mask_q[4+g] ||
        output_action[2*g +: 2] != `ACT_NONE); // [R06]
    end
  endgenerate

  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      pin_d[i] = timer_pin_out[i];
      if (fire[i]) begin
        pin_d[i] = apply_act(timer_pin_out[i],
          act_code(output_action, i[1:0])); // [R01]
      end
      if (fire[`CH7] && ovr_mask_q[4+i]) begin
        pin_d[i] = ovr_data_q[4+i]; // [R05] [R07]
      end
    end
  end

  // ****************************************************************
  // Counter next value
  // ****************************************************************
  always @* begin
    cnt_d = cnt_q;
    if (tick) begin
      cnt_d = cnt_inc; // [R08]
    end
    // Prescaler is not realigned by a load
    if (wr && test_mode) begin // [R10] [R11]
      if (idx == `IDX_CNT_WORD) begin
        cnt_d = pwdata[15:0]; // [R09]
      end else if (idx == `IDX_CNT_HI) begin
        cnt_d = {pwdata[7:0], cnt_q[7:0]};
      end else if (idx == `IDX_CNT_LO) begin
        cnt_d = {cnt_q[15:8], pwdata[7:0]};
      end
    end
  end

  // ****************************************************************
  // Flag next values; a set in the same cycle wins over a clear
  // ****************************************************************
  always @* begin
    chf_d = channel_flag;
    tof_d = counter_overflow_flag;
    accumulator_overflow_flag_d = accumulator_overflow_flag;
    accumulator_input_flag_d = accumulator_input_flag;
    if (wr && idx == `IDX_CH_FLAG) begin
      chf_d = chf_d & ~pwdata[7:4]; // [R20]
    end
    if (wr && idx == `IDX_OVF_FLAG && pwdata[`OVF_BIT]) begin
      tof_d = 1'b0; // [R20]
    end
    if (wr && idx == `IDX_ACC_FLAG) begin
      accumulator_overflow_flag_d = accumulator_overflow_flag_d && !pwdata[`ACC_OVF_BIT]; // [R20]
      accumulator_input_flag_d = accumulator_input_flag_d && !pwdata[`ACC_IN_BIT];
    end
    if (ffca) begin // [R19]
      if (access && is_tc &&
        (pwrite ? dir_q[4+tc_ch] : !dir_q[4+tc_ch])) begin
        chf_d[tc_ch] = 1'b0; // [R16]
      end
      if (cnt_acc) begin
        tof_d = 1'b0; // [R17]
      end
      if (acc_acc) begin
        accumulator_overflow_flag_d = 1'b0; // [R18]
        accumulator_input_flag_d = 1'b0;
      end
    end
    for (i = 0; i < 4; i = i + 1) begin
      if ((match[i] && !force_w[i]) || // [R04]
        (!dir_q[4+i] && active && capture_event[i])) begin
        chf_d[i] = 1'b1;
      end
    end
    if (tick && cnt_q == `CNT_MAX) begin
      tof_d = 1'b1;
    end
    if (acc_overflow_event) begin
      accumulator_overflow_flag_d = 1'b1;
    end
    if (acc_input_event) begin
      accumulator_input_flag_d = 1'b1;
    end
  end

  // ****************************************************************
  // Read data, latched in the setup cycle
  // ****************************************************************
  always @* begin
    rd_d = 32'h00000000;
    case (idx)
      `IDX_DIR: rd_d[7:0] = dir_q;
      `IDX_FORCE: rd_d[7:0] = `RST_BYTE; // [R02]
      `IDX_OVR_MASK: rd_d[7:0] = ovr_mask_q;
      `IDX_OVR_DATA: rd_d[7:0] = ovr_data_q;
      `IDX_CNT_HI: rd_d[7:0] = cnt_q[15:8];
      `IDX_CNT_LO: rd_d[7:0] = cnt_q[7:0];
      `IDX_CNT_WORD: rd_d[15:0] = cnt_q; // [R09]
      `IDX_SYSCTL: rd_d[7:4] = sysctl_q;
      `IDX_CH_FLAG: rd_d[7:4] = channel_flag;
      `IDX_OVF_FLAG: rd_d[`OVF_BIT] = counter_overflow_flag;
      `IDX_ACC_FLAG: rd_d[1:0] = {accumulator_overflow_flag,
        accumulator_input_flag};
      `IDX_ACC_HI: rd_d[7:0] = accumulator_count[15:8];
      `IDX_ACC_LO: rd_d[7:0] = accumulator_count[7:0];
      default: begin
        if (is_tc) begin
          rd_d[7:0] = idx[0] ? tc_q[tc_ch][7:0] : tc_q[tc_ch][15:8];
        end
      end
    endcase
    if (!aligned) begin
      rd_d = 32'h00000000;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= `RST_BYTE;
      ovr_mask_q <= `RST_BYTE;
      ovr_data_q <= `RST_BYTE;
      sysctl_q <= 4'h0;
      cnt_q <= `RST_WORD;
      pre_q <= 7'h00;
      for (i = 0; i < 4; i = i + 1) begin
        tc_q[i] <= `RST_WORD;
      end
      timer_pin_out <= 4'h0;
      channel_flag <= 4'h0;
      counter_overflow_flag <= 1'b0;
      accumulator_overflow_flag <= 1'b0;
      accumulator_input_flag <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      if (active) begin
        pre_q <= pre_q + 7'h01; // [R12]
      end
      cnt_q <= cnt_d;
      timer_pin_out <= pin_d;
      channel_flag <= chf_d;
      counter_overflow_flag <= tof_d;
      accumulator_overflow_flag <= accumulator_overflow_flag_d;
      accumulator_input_flag <= accumulator_input_flag_d;
      if (psel && !penable) begin
        prdata <= rd_d;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (!dir_q[4+i] && active && capture_event[i]) begin
          tc_q[i] <= cnt_q;
        end
      end
      if (wr) begin
        case (idx)
          `IDX_DIR: dir_q <= pwdata[7:0]; // [R01]
          `IDX_OVR_MASK: ovr_mask_q <= pwdata[7:0];
          `IDX_OVR_DATA: ovr_data_q <= pwdata[7:0];
          `IDX_SYSCTL: sysctl_q <= pwdata[7:4];
          default: begin
            if (is_tc && dir_q[4+tc_ch]) begin
              if (idx[0]) begin
                tc_q[tc_ch][7:0] <= pwdata[7:0];
              end else begin
                tc_q[tc_ch][15:8] <= pwdata[7:0];
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// [hw/timer_ctl_consts.vh]
/*
 * Register indices, field positions, reset values and codes of the
 * capture/compare timer control block.
 * Assumes byte address = 4 * index over a 32-bit APB bus.
 */
`ifndef TIMER_CTL_CONSTS_VH
`define TIMER_CTL_CONSTS_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDX_DIR 6'h00
`define IDX_FORCE 6'h01
`define IDX_OVR_MASK 6'h02
`define IDX_OVR_DATA 6'h03
`define IDX_CNT_HI 6'h04
`define IDX_CNT_LO 6'h05
`define IDX_SYSCTL 6'h06
`define IDX_CH_FLAG 6'h0E
`define IDX_OVF_FLAG 6'h0F
`define IDX_TC_FIRST 6'h18
`define IDX_TC_LAST 6'h1F
`define IDX_ACC_FLAG 6'h21
`define IDX_ACC_HI 6'h22
`define IDX_ACC_LO 6'h23
`define IDX_CNT_WORD 6'h30

// ****************************************************************
// Field positions
// ****************************************************************
`define SC_TEN 7
`define SC_SWAI 6
`define SC_SFRZ 5
`define SC_FFCA 4
`define OVF_BIT 7
`define ACC_OVF_BIT 1
`define ACC_IN_BIT 0
`define CH7 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CNT_MAX 16'hFFFF
`define PRE_MAX 7'h7F
`define DIV64_MASK 6'h3F
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

`endif

// [verification/timer_ctl_asserts.sv]
/* Port checker for timer_ctl.
   Assumes it is bound to timer_ctl and sees only its ports. */
`timescale 1ns/1ps
module timer_ctl_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire wait_mode,
  input wire [7:0] output_action,
  input wire [3:0] timer_pin_oe,
  input wire [3:0] channel_flag,
  input wire counter_overflow_flag,
  input wire accumulator_input_flag,
  input wire div64_tick,
  input wire timer_wake_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  reg [6:0] gap_q;
  reg seen_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 7'h00;
      seen_q <= 1'b0;
    end else if (div64_tick) begin
      gap_q <= 7'h00;
      seen_q <= 1'b1;
    end else if (gap_q != 7'h7F) begin
      gap_q <= gap_q + 7'h01;
    end
  end
  a_tick_spacing: assert property (
    div64_tick && seen_q |-> gap_q >= 7'h3F) else $error("tick too soon");
  a_wake_idle: assert property (
    !wait_mode |-> timer_wake_enable) else $error("wake dropped");
  a_wait_no_tick: assert property (
    !timer_wake_enable |-> !div64_tick) else $error("tick in wait");
  a_force_reads_zero: assert property (
    acc && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
    else $error("force read not zero");
  a_ovf_clear_cause: assert property (
    $fell(counter_overflow_flag) |-> $past(acc)) else $error("ovf lost");
  a_acc_clear_cause: assert property (
    $fell(accumulator_input_flag) |-> $past(acc)) else $error("acc lost");
  a_force_no_flag: assert property (
    $rose(channel_flag[0]) |->
    !$past(acc && pwrite && paddr == 8'h04 && pwdata[4]))
    else $error("force set flag");
  a_oe_by_write: assert property (
    $changed(timer_pin_oe) && $stable(output_action) |->
    $past(acc && pwrite)) else $error("oe moved alone");
  cover property (acc && pwrite && paddr == 8'h04);
  cover property (div64_tick);
  cover property ($fell(counter_overflow_flag));
endmodule
bind timer_ctl timer_ctl_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .wait_mode(wait_mode),
  .output_action(output_action), .timer_pin_oe(timer_pin_oe),
  .channel_flag(channel_flag), .div64_tick(div64_tick),
  .counter_overflow_flag(counter_overflow_flag),
  .accumulator_input_flag(accumulator_input_flag),
  .timer_wake_enable(timer_wake_enable));

// [verification/timer_ctl_bench.sv]
/* Self-checking bench for timer_ctl.
   Assumes the bench alone drives APB and all mode inputs. */
`timescale 1ns/1ps
module timer_ctl_bench;
  reg pclk, presetn, psel, penable, pwrite, slv;
  reg test_mode, wait_mode, freeze_mode, acc_overflow_event, acc_input_event;
  reg [7:0] paddr, output_action;
  reg [31:0] pwdata, q, r0;
  reg [2:0] prescale_sel;
  reg [3:0] capture_event;
  reg [15:0] accumulator_count;
  wire [31:0] prdata;
  wire pready, pslverr, counter_overflow_flag, accumulator_overflow_flag;
  wire accumulator_input_flag, div64_tick, timer_wake_enable;
  wire [3:0] timer_pin_out, timer_pin_oe, channel_flag;
  integer err_count, n_checks, n;
  timer_ctl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_mode(test_mode), .wait_mode(wait_mode),
    .freeze_mode(freeze_mode), .prescale_sel(prescale_sel),
    .output_action(output_action), .capture_event(capture_event),
    .acc_overflow_event(acc_overflow_event),
    .acc_input_event(acc_input_event),
    .accumulator_count(accumulator_count), .timer_pin_out(timer_pin_out),
    .timer_pin_oe(timer_pin_oe), .channel_flag(channel_flag),
    .counter_overflow_flag(counter_overflow_flag),
    .accumulator_overflow_flag(accumulator_overflow_flag),
    .accumulator_input_flag(accumulator_input_flag),
    .div64_tick(div64_tick), .timer_wake_enable(timer_wake_enable));
  // ******************************************************
  // Shared tasks
  // ******************************************************
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("FAIL %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      i = 0;
      while (pready !== 1'b1 && i < 16) begin
        @(posedge pclk);
        i = i + 1;
      end
      if (i == 16) begin
        err_count = err_count + 1;
        results;
      end
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask
  task ticks;
    begin
      n = 0;
      repeat (128) begin
        @(posedge pclk);
        if (div64_tick === 1'b1) n = n + 1;
      end
    end
  endtask
  // ******************************************************
  // Scenarios
  // ******************************************************
  task t_reset;
    begin
      chk("oe", 0, timer_pin_oe);
      chk("flags", 0, {channel_flag, counter_overflow_flag});
      apb(0, 8'h00, 0);
      chk("dir", 0, q);
      apb(0, 8'h18, 0);
      chk("sysctl", 0, q);
    end
  endtask
  task t_count;
    begin
      apb(1, 8'hC0, 32'h1234);
      apb(0, 8'hC0, 0);
      chk("cnt", 0, q);
      test_mode <= 1'b1;
      apb(1, 8'hC0, 32'hFFFE);
      apb(0, 8'h10, 0);
      chk("cnt_hi", 8'hFF, q);
      repeat (8) @(posedge pclk);
      apb(0, 8'hC0, 0);
      chk("cnt", 16'hFFFE, q);
      apb(1, 8'h18, 32'h80);
      apb(0, 8'hC0, 0);
      r0 = q;
      apb(0, 8'hC0, 0);
      chk("cnt_step", (r0 + 3) & 32'hFFFF, q);
      chk("ovf", 1, counter_overflow_flag);
      apb(0, 8'h14, 0);
      chk("ovf", 1, counter_overflow_flag);
      apb(1, 8'h3C, 0);
      chk("ovf", 1, counter_overflow_flag);
      apb(1, 8'h3C, 32'h80);
      chk("ovf", 0, counter_overflow_flag);
      apb(1, 8'h18, 32'h90);
      apb(1, 8'hC0, 32'hFFFF);
      repeat (4) @(posedge pclk);
      apb(0, 8'h14, 0);
      chk("ovf", 0, counter_overflow_flag);
      apb(1, 8'h18, 0);
      test_mode <= 1'b0;
    end
  endtask
  task t_force;
    begin
      prescale_sel <= 3'h7;
      apb(1, 8'h18, 32'h80);
      apb(1, 8'h08, 32'h10);
      apb(1, 8'h00, 32'hF0);
      chk("oe", 4'h1, timer_pin_oe);
      apb(1, 8'h00, 32'hE0);
      chk("oe", 4'h0, timer_pin_oe);
      output_action <= 8'h0F;
      apb(1, 8'h08, 0);
      apb(1, 8'h00, 32'hF0);
      apb(1, 8'h04, 32'h30);
      chk("pin", 4'h3, timer_pin_out);
      chk("chf", 0, channel_flag);
      apb(0, 8'h04, 0);
      chk("force_rd", 0, q);
      apb(1, 8'h08, 32'h30);
      apb(1, 8'h0C, 32'h20);
      apb(1, 8'h04, 32'h90);
      chk("pin", 4'h2, timer_pin_out);
      output_action <= 8'h00;
      apb(1, 8'h18, 0);
    end
  endtask
  task t_acc;
    begin
      acc_overflow_event <= 1'b1;
      acc_input_event <= 1'b1;
      @(posedge pclk);
      acc_overflow_event <= 1'b0;
      acc_input_event <= 1'b0;
      @(posedge pclk);
      apb(0, 8'h88, 0);
      chk("acc_hi", 8'hA5, q);
      chk("accf", 2'h3,
        {accumulator_overflow_flag, accumulator_input_flag});
      apb(1, 8'h84, 32'h01);
      chk("accf", 2'h2,
        {accumulator_overflow_flag, accumulator_input_flag});
      apb(1, 8'h18, 32'h10);
      apb(0, 8'h8C, 0);
      chk("accf", 2'h0,
        {accumulator_overflow_flag, accumulator_input_flag});
      apb(1, 8'h18, 0);
    end
  endtask
  task t_tick;
    begin
      ticks;
      chk("ticks", 0, n);
      apb(1, 8'h18, 32'h80);
      ticks;
      chk("ticks", 2, n);
      wait_mode <= 1'b1;
      apb(1, 8'h18, 32'hC0);
      ticks;
      chk("ticks", 0, n);
      chk("wake", 0, timer_wake_enable);
      wait_mode <= 1'b0;
      freeze_mode <= 1'b1;
      apb(1, 8'h18, 32'hA0);
      apb(0, 8'hC0, 0);
      r0 = q;
      ticks;
      chk("ticks", 2, n);
      apb(0, 8'hC0, 0);
      chk("cnt", r0, q);
      freeze_mode <= 1'b0;
    end
  endtask
  task t_cap;
    begin
      apb(1, 8'h18, 32'h90);
      apb(1, 8'h00, 32'hE0);
      capture_event <= 4'h3;
      @(posedge pclk);
      capture_event <= 4'h0;
      repeat (2) @(posedge pclk);
      #1;
      chk("chf", 4'h1, channel_flag);
      apb(0, 8'h60, 0);
      chk("chf", 4'h0, channel_flag);
      apb(0, 8'h40, 0);
      chk("slverr", 1, slv);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, test_mode, wait_mode, freeze_mode} = 6'h00;
    {acc_overflow_event, acc_input_event, presetn} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    prescale_sel = 3'h0;
    output_action = 8'h00;
    capture_event = 4'h0;
    accumulator_count = 16'hA55A;
    err_count = 0;
    n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_count;
    t_force;
    t_acc;
    t_tick;
    t_cap;
    results;
  end
endmodule
